// ---- verilog/ums_spi_master.sv ----
// Purpose: Master-only full-duplex serial peripheral port with buffered transmit and receive
// Assumes: Software drives the control ports synchronously to sys_clk
// Notes:   Contract list below; the receive pin is synchronised, costing two cycles of sampling lag
//
// Contract
// - Four clock modes from polarity and phase; mode is polarity*2 plus phase
// - Outgoing data changes on one clock edge, incoming sampled on the other
// - Frames are exactly eight data bits, no start, stop or parity
// - One bit-order setting serves both transmit and receive
// - Queued frame follows with no gap, otherwise data line idles high
// - Two back-to-back bytes shift consecutively; completion only after both
// - Transmitter works alone; receiver only receives while transmitter enabled
// - Rate register resets to zero
// - Enabled transmitter takes the output pin as serial data output
// - Enabled receiver takes the input pin as serial data input
// - Clock pin carries the generated transfer clock only while the transmitter holds its pins and clock_pin_direction_bit is set
// - A data write alone starts a transfer; reception runs alongside
// - Written byte waits in buffer until the shift register is free
// - On receive overflow the newest byte is dropped, older ones kept
// - Framing, overrun and parity error bits always read zero
// - Bit order one sends least significant bit first, zero most first
// - Receive-complete follows unread data; disabling receiver flushes buffer
// - Transmit-complete sets when done with nothing queued; clears on ack or write-one
// - Buffer-empty is one when a byte may be written, set after reset

`timescale 1ns/1ns
`default_nettype none

module ums_spi_master #(
  parameter int RATE_W   = ums_pkg::RATE_W_DEF,
  parameter int RX_DEPTH = ums_pkg::RX_DEPTH_DEF
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire ums_pkg::ums_cfg_s    cfg,
  input  wire ums_pkg::ums_irq_en_s irq_en,
  input  wire logic                 rate_wr,
  input  wire logic [RATE_W-1:0]    rate_wdata,
  input  wire logic                 data_wr,
  input  wire logic [7:0]           data_wdata,
  input  wire logic                 data_rd,
  input  wire logic                 txc_clear,
  input  wire logic                 txc_irq_ack,
  input  wire logic                 serial_in_pin,
  output logic [7:0]                rx_data,
  output logic [RATE_W-1:0]         rate_divider_reg,
  output ums_pkg::ums_status_s      status_reg_a,
  output ums_pkg::ums_irq_s         irq_req,
  output logic [1:0]                spi_mode,
  output logic                      busy,
  output logic                      serial_out_pin,
  output logic                      serial_out_oe,
  output logic                      serial_in_owned,
  output logic                      transfer_clock_pin,
  output logic                      transfer_clock_oe
);

  localparam int PTR_W = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
  localparam int CNT_W = $clog2(RX_DEPTH + 1);

  // Half-period counter must span exactly two edges per data bit
  if (2 * ums_pkg::FRAME_BITS != (1 << ums_pkg::HALF_W)) begin : g_bad_frame
    $error("HALF_W does not match FRAME_BITS");
  end
  if (RATE_W < 1 || RATE_W > ums_pkg::RATE_W_MAX) begin : g_bad_rate
    $error("RATE_W out of range");
  end
  // A one-entry buffer would wrap a one-bit pointer past the array
  if (RX_DEPTH < 2 || (RX_DEPTH & (RX_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("RX_DEPTH must be a power of two, two or more");
  end

  ums_pkg::ums_state_e st_r;
  ums_pkg::ums_state_e st_nxt;

  logic [RATE_W-1:0] rate_r;
  logic [RATE_W-1:0] div_r;
  logic [RATE_W-1:0] div_nxt;
  logic [3:0]        half_r;
  logic [3:0]        half_nxt;
  logic              level_r;
  logic              level_nxt;
  logic              sck_r;
  logic              sout_r;
  logic              sout_nxt;
  logic [7:0]        sh_r;
  logic [7:0]        sh_nxt;
  logic [7:0]        rxsh_r;
  logic [7:0]        rxsh_nxt;
  logic [7:0]        buf_r;
  logic              buf_full_r;
  logic              buf_full_nxt;
  logic              txc_r;
  logic              txc_nxt;
  logic              tx_on_r;
  logic              tx_on_nxt;
  logic              din_meta_r;
  logic              din_r;
  logic [7:0]        rx_data_r;
  logic [7:0]        rx_mem [RX_DEPTH];
  logic [PTR_W-1:0]  wp_r;
  logic [PTR_W-1:0]  rp_r;
  logic [CNT_W-1:0]  cnt_r;
  logic [CNT_W-1:0]  cnt_nxt;

  // Edge scheduling: 16 half periods per frame, even ones end on a leading edge
  wire shifting   = (st_r == ums_pkg::UMS_SHIFT);
  wire tick       = shifting && (div_r == rate_r);
  wire last_edge  = tick && (half_r == ums_pkg::HALF_LAST);
  wire samp_edge  = tick && (half_r[0] == cfg.clock_phase_bit);
  wire shift_edge = tick && !samp_edge && (half_r != ums_pkg::HALF_FIRST) && !last_edge;
  // Phase-one frames end on a sampling edge: the data line waits one more cycle
  // so that the slave never sees data and clock move on the same edge
  wire hold_out   = last_edge && samp_edge;

  // Transmit buffer: write accepted only while enabled and free
  wire wr_ok     = data_wr && cfg.transmitter_enable_bit && !buf_full_r;
  wire start     = buf_full_r && (!shifting || last_edge);
  wire txc_set   = last_edge && !buf_full_r;
  wire txc_clr   = txc_clear || txc_irq_ack;

  // Receive buffer handshakes
  wire fifo_full = (cnt_r == CNT_W'(RX_DEPTH));
  wire fifo_has  = (cnt_r != '0);
  wire rx_on     = cfg.receiver_enable_bit && cfg.transmitter_enable_bit;
  wire push      = last_edge && rx_on && !fifo_full;
  wire pop       = data_rd && fifo_has;

  wire lsb_first = cfg.bit_order_bit;
  wire out_bit   = lsb_first ? sh_nxt[0] : sh_nxt[7];
  // Both directions move the same way, so one order bit serves them
  wire [7:0] tx_step = lsb_first ? {1'b0, sh_r[7:1]} : {sh_r[6:0], 1'b0};
  wire [7:0] rx_step = lsb_first ? {din_r, rxsh_r[7:1]} : {rxsh_r[6:0], din_r};

  assign st_nxt = start ? ums_pkg::UMS_SHIFT :
                  (last_edge ? ums_pkg::UMS_IDLE : st_r);

  // Divider idles at zero so a frame's first half period is a full one
  assign div_nxt = (start || tick || !shifting) ? '0 : div_r + RATE_W'(1);

  assign half_nxt = start ? ums_pkg::HALF_FIRST :
                    (tick ? half_r + 4'h1 : half_r);

  assign level_nxt = (start || !shifting) ? 1'b0 : (level_r ^ tick);

  assign sh_nxt = start ? buf_r :
                  (shift_edge ? tx_step : sh_r);

  assign sout_nxt = hold_out ? sout_r :
                    ((st_nxt == ums_pkg::UMS_SHIFT) ? out_bit : ums_pkg::IDLE_LINE);

  assign rxsh_nxt = !samp_edge ? rxsh_r :
                    rx_step;

  assign buf_full_nxt = wr_ok || (buf_full_r && !start);

  // Set wins over a clear in the same cycle
  assign txc_nxt = txc_set || (txc_r && !txc_clr);

  // Disable takes effect only after the shift register and buffer drain
  assign tx_on_nxt = cfg.transmitter_enable_bit || (st_nxt == ums_pkg::UMS_SHIFT)
                     || buf_full_nxt;

  assign cnt_nxt = !rx_on ? '0 : cnt_r + CNT_W'(push) - CNT_W'(pop);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r    <= ums_pkg::UMS_IDLE;
      div_r   <= '0;
      half_r  <= ums_pkg::HALF_FIRST;
      level_r <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      div_r   <= div_nxt;
      half_r  <= half_nxt;
      level_r <= level_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rate_r <= '0;
    end else if (rate_wr) begin
      rate_r <= rate_wdata;
    end
  end

  // Clock and data leave from flops, so no decode glitch reaches the slave
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sck_r  <= 1'b0;
      sout_r <= ums_pkg::IDLE_LINE;
    end else begin
      sck_r  <= cfg.clock_polarity_bit ^ level_nxt;
      sout_r <= sout_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sh_r   <= '0;
      rxsh_r <= '0;
    end else begin
      sh_r   <= sh_nxt;
      rxsh_r <= rxsh_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      buf_r <= '0;
    end else if (wr_ok) begin
      buf_r <= data_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      buf_full_r <= 1'b0;
      txc_r      <= 1'b0;
      tx_on_r    <= 1'b0;
    end else begin
      buf_full_r <= buf_full_nxt;
      txc_r      <= txc_nxt;
      tx_on_r    <= tx_on_nxt;
    end
  end

  // Receive pin comes from the slave and is foreign to sys_clk
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      din_meta_r <= 1'b0;
      din_r      <= 1'b0;
    end else begin
      din_meta_r <= serial_in_pin;
      din_r      <= din_meta_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      rx_mem[wp_r] <= rxsh_nxt;
    end
  end

  // Receiver disable flushes at the next edge; both pointers restart together
  always_ff @(posedge sys_clk) begin
    if (rst || !rx_on) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= PTR_W'(wp_r + PTR_W'(1));
      end
      if (pop) begin
        rp_r <= PTR_W'(rp_r + PTR_W'(1));
      end
      cnt_r <= cnt_nxt;
    end
  end

  // Read data appears the cycle after the read strobe and holds until the next read
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_data_r <= '0;
    end else if (pop) begin
      rx_data_r <= rx_mem[rp_r];
    end
  end

  assign rx_data          = rx_data_r;
  assign rate_divider_reg = rate_r;
  assign spi_mode         = {cfg.clock_polarity_bit, cfg.clock_phase_bit};
  assign busy             = shifting || buf_full_r;

  assign status_reg_a.receive_complete_flag  = fifo_has;
  assign status_reg_a.transmit_complete_flag = txc_r;
  assign status_reg_a.tx_buffer_empty_flag   = !buf_full_r;
  assign status_reg_a.framing_error_flag     = ums_pkg::ERR_UNUSED;
  assign status_reg_a.data_overrun_flag      = ums_pkg::ERR_UNUSED;
  assign status_reg_a.parity_error_flag      = ums_pkg::ERR_UNUSED;

  assign irq_req.rxc  = irq_en.global_irq_en && irq_en.rxc_irq_en && fifo_has;
  assign irq_req.txc  = irq_en.global_irq_en && irq_en.txc_irq_en && txc_r;
  assign irq_req.udre = irq_en.global_irq_en && irq_en.udre_irq_en && !buf_full_r;

  // Pin ownership; released pins fall back to general-purpose port control
  assign serial_out_pin     = sout_r;
  assign serial_out_oe      = tx_on_r;
  assign serial_in_owned    = cfg.receiver_enable_bit;
  assign transfer_clock_pin = sck_r;
  assign transfer_clock_oe  = cfg.clock_pin_direction_bit && tx_on_r;

endmodule // ums_spi_master

`default_nettype wire

// ---- verilog/ums_pkg.sv ----
// Purpose: Shared constants and types for the master-only serial peripheral port
// Assumes: Eight-bit frames, half-period divider driven from sys_clk
// Notes:   Widths that may differ are parameters of the top module

package ums_pkg;

  localparam int          FRAME_BITS    = 8;
  localparam int          HALF_W        = 4;
  localparam logic [3:0]  HALF_FIRST    = 4'h0;
  localparam logic [3:0]  HALF_LAST     = 4'hF;
  localparam logic        IDLE_LINE     = 1'h1;
  localparam logic        ERR_UNUSED    = 1'h0;
  localparam int          RATE_W_DEF    = 12;
  localparam int          RATE_W_MAX    = 16;
  localparam int          RX_DEPTH_DEF  = 2;
  localparam real         SYS_CLK_NS    = 8.0;

  typedef enum logic [0:0] {
    UMS_IDLE,
    UMS_SHIFT
  } ums_state_e;

  // Software-held configuration bits
  typedef struct packed {
    logic clock_polarity_bit;
    logic clock_phase_bit;
    logic bit_order_bit;
    logic transmitter_enable_bit;
    logic receiver_enable_bit;
    logic clock_pin_direction_bit;
  } ums_cfg_s;

  typedef struct packed {
    logic rxc_irq_en;
    logic txc_irq_en;
    logic udre_irq_en;
    logic global_irq_en;
  } ums_irq_en_s;

  typedef struct packed {
    logic receive_complete_flag;
    logic transmit_complete_flag;
    logic tx_buffer_empty_flag;
    logic framing_error_flag;
    logic data_overrun_flag;
    logic parity_error_flag;
  } ums_status_s;

  typedef struct packed {
    logic rxc;
    logic txc;
    logic udre;
  } ums_irq_s;

endpackage

// ---- test/ums_spi_master_asserts.sv ----
// Purpose: Port checks for the master serial port
// Assumes: One clock domain, synchronous reset
// Notes:   Bound to every instance of the design
`timescale 1ns/1ns
`default_nettype none
module ums_spi_master_chk #(
  parameter int RATE_W = 12
) (
  input wire logic                 sys_clk,
  input wire logic                 rst,
  input wire ums_pkg::ums_cfg_s    cfg,
  input wire ums_pkg::ums_irq_en_s irq_en,
  input wire logic                 data_wr,
  input wire logic                 txc_clear,
  input wire logic [RATE_W-1:0]    rate_divider_reg,
  input wire ums_pkg::ums_status_s status_reg_a,
  input wire ums_pkg::ums_irq_s    irq_req,
  input wire logic [1:0]           spi_mode,
  input wire logic                 busy,
  input wire logic                 serial_out_pin,
  input wire logic                 transfer_clock_pin
);
  wire txc = status_reg_a.transmit_complete_flag;
  wire rxc = status_reg_a.receive_complete_flag;
  wire udre = status_reg_a.tx_buffer_empty_flag;
  wire gie = irq_en.global_irq_en;
  logic              ck_r;
  logic              seen_r;
  logic [RATE_W:0]   gap_r;
  wire tog = transfer_clock_pin != ck_r;
  // Gap restarts whenever busy drops, so only toggle-to-toggle spacing is judged
  always_ff @(posedge sys_clk) begin
    ck_r <= transfer_clock_pin;
    if (rst || !busy) begin
      gap_r <= '0;
      seen_r <= 1'h0;
    end else if (tog) begin
      gap_r <= (RATE_W+1)'(1);
      seen_r <= 1'h1;
    end else begin
      gap_r <= gap_r + 1'b1;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_err_zero: assert property ({status_reg_a.framing_error_flag,
    status_reg_a.data_overrun_flag, status_reg_a.parity_error_flag} == 3'h0) else $error("err");
  a_mode_num: assert property (spi_mode == {cfg.clock_polarity_bit,
    cfg.clock_phase_bit}) else $error("mode");
  a_txc_irq: assert property (irq_req.txc == (gie & irq_en.txc_irq_en & txc))
    else $error("txc irq");
  a_udre_irq: assert property (irq_req.udre == (gie & irq_en.udre_irq_en & udre))
    else $error("udre irq");
  a_idle_high: assert property (!busy && $past(!busy) && !$past(rst) |-> serial_out_pin)
    else $error("idle line");
  a_clk_idle: assert property (!busy && $past(!busy) && !$past(rst)
    && $stable(cfg.clock_polarity_bit) |-> transfer_clock_pin == cfg.clock_polarity_bit)
    else $error("idle clock");
  a_write_taken: assert property (data_wr && udre && cfg.transmitter_enable_bit
    |=> !udre && busy) else $error("write");
  a_no_start: assert property (!data_wr && !busy |=> !busy) else $error("start");
  a_rx_flush: assert property ((!cfg.receiver_enable_bit)[*2] |-> !rxc)
    else $error("flush");
  a_txc_clear: assert property (txc_clear && !busy |=> !txc) else $error("txc clr");
  a_half_period: assert property (busy && seen_r && tog
    |-> gap_r == rate_divider_reg + 1'b1) else $error("half period");
  c_txc: cover property ($rose(txc));
  c_rxc: cover property ($rose(rxc));
  c_refused: cover property (data_wr && !udre);
endmodule // ums_spi_master_chk
bind ums_spi_master ums_spi_master_chk #(.RATE_W(RATE_W)) i_ums_spi_master_chk (
  .sys_clk(sys_clk), .rst(rst), .cfg(cfg), .irq_en(irq_en), .data_wr(data_wr),
  .txc_clear(txc_clear), .rate_divider_reg(rate_divider_reg), .status_reg_a(status_reg_a),
  .irq_req(irq_req), .spi_mode(spi_mode), .busy(busy), .serial_out_pin(serial_out_pin),
  .transfer_clock_pin(transfer_clock_pin));
`default_nettype wire

// ---- test/ums_slave_model.sv ----
// Purpose: Loop-back slave at the serial side
// Assumes: Mode and bit order set like the master
// Notes:   Replies with the inverse of the last byte it took in
`timescale 1ns/1ns
`default_nettype none
module ums_slave_model (
  input  wire logic  rst,
  input  wire logic  sck,
  input  wire logic  mosi,
  input  wire logic  pol,
  input  wire logic  pha,
  input  wire logic  lsb,
  output logic       miso,
  output logic [7:0] got,
  output int         frames
);
  logic [7:0] sh = 8'h00;
  logic [7:0] rep = 8'hA5;
  logic       alt = 1'h0;
  int         e = 0;
  int         k;
  initial got = 8'h00;
  initial frames = 0;
  // An idle-level move at frame start is a polarity change, not a clock edge
  always @(posedge sck or negedge sck) begin
    if (rst) begin
      e = 0;
    end else if (!(e == 0 && sck == pol)) begin
      if ((sck != pol) != pha) begin
        sh = lsb ? {mosi, sh[7:1]} : {sh[6:0], mosi};
      end
      e = e + 1;
      if (e == 16) begin
        e = 0;
        alt = ~miso;
        got = sh;
        rep = ~sh;
        frames = frames + 1;
      end
    end
  end
  always @* begin
    k = (e - int'(pha)) >>> 1;
    miso = (pha && e == 0) ? alt : rep[lsb ? k : 7 - k];
  end
endmodule // ums_slave_model
`default_nettype wire

// ---- test/usart_master_spi_mode_tb.sv ----
// Purpose: Self-checking bench for the master serial port
// Assumes: Loop-back slave model on the serial side
// Notes:   Rate 2 keeps the synchronised input well inside each bit
`timescale 1ns/1ns
`default_nettype none
module usart_master_spi_mode_tb;
  logic                 sys_clk = 1'h0, rst = 1'h1, rd_d = 1'h0;
  logic                 rate_wr = 1'h0, data_wr = 1'h0, data_rd = 1'h0;
  logic                 txc_clear = 1'h0, txc_irq_ack = 1'h0;
  ums_pkg::ums_cfg_s    cfg = '0;
  ums_pkg::ums_irq_en_s irq_en = '0;
  logic [11:0]          rate_wdata = 12'h000, rate_q;
  logic [7:0]           data_wdata = 8'h00, rx_data, got, srep = 8'hA5;
  ums_pkg::ums_status_s st;
  ums_pkg::ums_irq_s    irq;
  logic [1:0]           mode;
  logic                 busy, sout, soe, sin_own, sck, sck_oe, miso, exp_irq;
  int                   fail_count = 0, tests_run = 0, seed = 38, frames, rx_held = 0, n0;
  logic [7:0]           q_wire[$], q_rx[$];
  ums_spi_master i_ums_spi_master (.sys_clk(sys_clk), .rst(rst), .cfg(cfg), .irq_en(irq_en),
    .rate_wr(rate_wr), .rate_wdata(rate_wdata), .data_wr(data_wr), .data_wdata(data_wdata),
    .data_rd(data_rd), .txc_clear(txc_clear), .txc_irq_ack(txc_irq_ack),
    .serial_in_pin(miso), .rx_data(rx_data), .rate_divider_reg(rate_q), .status_reg_a(st),
    .irq_req(irq), .spi_mode(mode), .busy(busy), .serial_out_pin(sout), .serial_out_oe(soe),
    .serial_in_owned(sin_own), .transfer_clock_pin(sck), .transfer_clock_oe(sck_oe));
  ums_slave_model i_ums_slave_model (.rst(rst), .sck(sck), .mosi(sout),
    .pol(cfg.clock_polarity_bit), .pha(cfg.clock_phase_bit), .lsb(cfg.bit_order_bit),
    .miso(miso), .got(got), .frames(frames));
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    tests_run++;
    if (exp !== seen) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results;
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic step;
    @(negedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] w);
    int i;
    for (i = 0; i < 500 && st.tx_buffer_empty_flag !== 1'h1; i++) begin
      step;
    end
    if (i == 500) begin
      fail_count++;
      results;
    end
    data_wdata = w;
    data_wr = 1'h1;
    q_wire.push_back(w);
    if (cfg.receiver_enable_bit && rx_held < 2) begin
      q_rx.push_back(srep);
      rx_held++;
    end
    srep = ~w;
    step;
    data_wr = 1'h0;
  endtask
  task automatic wait_clr(input logic ack);
    int i;
    for (i = 0; i < 2000 && st.transmit_complete_flag !== 1'h1; i++) begin
      step;
    end
    if (i == 2000) begin
      fail_count++;
      results;
    end
    txc_clear = !ack;
    txc_irq_ack = ack;
    step;
    txc_clear = 1'h0;
    txc_irq_ack = 1'h0;
    step;
    check("txc", 32'h0, 32'(st.transmit_complete_flag));
  endtask
  task automatic rd;
    data_rd = 1'h1;
    step;
    data_rd = 1'h0;
    rx_held = rx_held > 0 ? rx_held - 1 : 0;
    step;
  endtask
  always @(posedge sys_clk) rd_d <= data_rd && st.receive_complete_flag;
  always @(negedge sys_clk) if (rd_d) check("rx", 32'(q_rx.pop_front()), 32'(rx_data));
  always @(frames) check("wire", 32'(q_wire.pop_front()), 32'(got));
  initial begin
    repeat (16) step;
    rst = 1'h0;
    step;
    check("rate", 32'h0, 32'(rate_q));
    cfg.clock_pin_direction_bit = 1'h1;
    cfg.transmitter_enable_bit = 1'h1;
    step;
    rate_wdata = 12'h002;
    rate_wr = 1'h1;
    step;
    rate_wr = 1'h0;
    for (int m = 0; m < 10; m++) begin
      cfg.clock_polarity_bit = m[1];
      cfg.clock_phase_bit = m[0];
      cfg.bit_order_bit = m[2];
      cfg.receiver_enable_bit = (m != 5);
      irq_en = 4'($random(seed));
      step;
      check("oe", 32'h3, 32'({soe, sck_oe}));
      check("in own", 32'(cfg.receiver_enable_bit), 32'(sin_own));
      n0 = frames;
      wr(8'($random(seed)));
      wr(8'($random(seed)));
      if (m == 8) wr(8'($random(seed)));
      wait_clr(m[0]);
      check("frames", 32'(n0 + (m == 8 ? 3 : 2)), 32'(frames));
      check("rxc set", 32'(q_rx.size() != 0), 32'(st.receive_complete_flag));
      exp_irq = irq_en.global_irq_en && irq_en.rxc_irq_en && q_rx.size() != 0;
      check("rxc irq", 32'(exp_irq), 32'(irq.rxc));
      if (m == 9) begin
        cfg.receiver_enable_bit = 1'h0;
        step;
        step;
        check("rxc", 32'h0, 32'(st.receive_complete_flag));
        q_rx = {};
        rx_held = 0;
      end
      repeat (3) rd;
    end
    check("left", 32'h0, 32'(q_wire.size() + q_rx.size()));
    results;
  end
endmodule // usart_master_spi_mode_tb
`default_nettype wire
